// ---- timer8_waveform_generator.v ----
// 8-bit timer with two compare channels, waveform modes and an APB register file.
// Assumes one clock pclk, asynchronous active-low reset, and an external count pin
// that is asynchronous to pclk.
`timescale 1ns/10ps
`include "timer8_regs.vh"
module timer8_waveform_generator
(
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // External count source
    input wire ext_count_pin,
    // Waveform outputs and their drive enables
    output wire wave_out_a,
    output wire wave_out_b,
    output wire wave_en_a,
    output wire wave_en_b,
    // Interrupt request, level
    output reg irq
);

    // Control and data registers
    reg [7:0] ctrl_a_ff; // Actions and low mode bits
    reg [3:0] ctrl_b_ff; // High mode bit and clock select
    reg [7:0] count_ff; // Counter value
    reg [7:0] cmp_buf_a_ff; // Compare A as written
    reg [7:0] cmp_buf_b_ff; // Compare B as written
    reg [7:0] cmp_act_a_ff; // Compare A in use
    reg [7:0] cmp_act_b_ff; // Compare B in use
    reg [2:0] mask_ff; // Interrupt masks
    reg [2:0] flag_ff; // Sticky flags
    reg up_ff; // Count direction
    reg [9:0] presc_ff; // Prescaler counter
    reg [2:0] pin_sync_ff; // Pin synchroniser plus edge stage
    reg [1:0] wave_ff; // Waveform output state
    reg [1:0] wave_en_ff; // Waveform pin enables

    // Decoded fields
    wire [2:0] mode = {ctrl_b_ff[`CB_MODE_HI], ctrl_a_ff[1:0]};
    wire [2:0] clk_sel = ctrl_b_ff[2:0];
    wire is_phase = (mode == 3'd1) || (mode == 3'd5);
    wire is_fast = (mode == 3'd3) || (mode == 3'd7);
    wire top_from_compare_a = (mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7);
    wire is_immediate = (mode == 3'd0) || (mode == 3'd2);
    // Reserved codes halt the counter
    wire is_reserved = (mode == 3'd4) || (mode == 3'd6);

    // Current TOP value
    wire [7:0] top_val = top_from_compare_a ? cmp_act_a_ff : `TOP_FIXED;
    wire at_top = (count_ff == top_val);
    wire at_bottom = (count_ff == `BOTTOM);

    // APB phase decode
    wire acc = psel && penable;
    wire done = acc && pready;
    wire wr_done = done && pwrite;
    wire rd_done = done && !pwrite;

    // Prescaler tick selection
    reg tick;
    wire pin_rise = pin_sync_ff[1] && !pin_sync_ff[2];
    wire pin_fall = !pin_sync_ff[1] && pin_sync_ff[2];

    // Clock select: source and edge
    always @*
    begin
        case (clk_sel)
            3'd1: tick = 1'b1;
            3'd2: tick = ((presc_ff & `DIV8_MASK) == `DIV8_MASK);
            3'd3: tick = ((presc_ff & `DIV64_MASK) == `DIV64_MASK);
            3'd4: tick = ((presc_ff & `DIV256_MASK) == `DIV256_MASK);
            3'd5: tick = ((presc_ff & `DIV1024_MASK) == `DIV1024_MASK);
            3'd6: tick = pin_fall;
            3'd7: tick = pin_rise;
            default: tick = 1'b0;
        endcase
    end

    // Counter events on a timer tick
    wire run = tick && !is_reserved;
    wire top_ev = run && at_top && (!is_phase || up_ff);
    wire bot_ev = run && is_phase && !up_ff && at_bottom;
    wire [1:0] match;
    assign match[0] = run && (count_ff == cmp_act_a_ff);
    assign match[1] = run && (count_ff == cmp_act_b_ff);

    // Overflow condition per mode
    reg ovf_ev;
    always @*
    begin
        if (is_phase)
            ovf_ev = bot_ev;
        else if (mode == 3'd7)
            ovf_ev = run && at_top;
        else
            ovf_ev = run && (count_ff == `TOP_FIXED);
    end

    // Buffer load strobe
    wire load_buf = is_immediate || (is_phase && top_ev) || (is_fast && run && at_top);

    // Register writes
    wire wr_ctrl_a = wr_done && (paddr == `OFS_CTRL_A);
    wire wr_ctrl_b = wr_done && (paddr == `OFS_CTRL_B);
    wire wr_count = wr_done && (paddr == `OFS_COUNT);
    wire wr_cmp_a = wr_done && (paddr == `OFS_CMP_A);
    wire wr_cmp_b = wr_done && (paddr == `OFS_CMP_B);
    wire wr_mask = wr_done && (paddr == `OFS_MASK);
    wire rd_flag = rd_done && (paddr == `OFS_FLAG);

    // Flag update: set wins over read-clear
    wire [2:0] flag_set = {match[1], match[0], ovf_ev};
    // Clear only the bits the read returned, so a flag set after capture survives
    wire [2:0] flag_clr = rd_flag ? prdata[2:0] : 3'b000;
    wire [2:0] nxt_flag = (flag_ff & ~flag_clr) | flag_set;

    // Address decode for reads
    reg [31:0] nxt_rdata;
    reg nxt_err;
    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (paddr)
            `OFS_CTRL_A: nxt_rdata[7:0] = {ctrl_a_ff[7:4], 2'b00, ctrl_a_ff[1:0]};
            `OFS_CTRL_B: nxt_rdata[3:0] = ctrl_b_ff;
            `OFS_COUNT: nxt_rdata[7:0] = count_ff;
            `OFS_CMP_A: nxt_rdata[7:0] = cmp_buf_a_ff;
            `OFS_CMP_B: nxt_rdata[7:0] = cmp_buf_b_ff;
            `OFS_MASK: nxt_rdata[2:0] = mask_ff;
            `OFS_FLAG: nxt_rdata[2:0] = flag_ff;
            default: nxt_err = 1'b1;
        endcase
    end

    // APB answer: one wait state, data and error from flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            // Raise ready on first access cycle, drop after completion
            pready <= acc && !pready;
            if (acc && !pready)
            begin
                prdata <= pwrite ? 32'h0000_0000 : nxt_rdata;
                pslverr <= nxt_err;
            end
            else
            begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Software-written control registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a_ff <= `RST_BYTE;
            ctrl_b_ff <= 4'h0;
            mask_ff <= 3'b000;
        end
        else
        begin
            // Reserved bits never stored
            if (wr_ctrl_a)
                ctrl_a_ff <= {pwdata[7:4], 2'b00, pwdata[1:0]};
            if (wr_ctrl_b)
                ctrl_b_ff <= pwdata[3:0];
            if (wr_mask)
                mask_ff <= pwdata[2:0];
        end
    end

    // Compare buffers and active compare values
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_buf_a_ff <= `RST_BYTE;
            cmp_buf_b_ff <= `RST_BYTE;
            cmp_act_a_ff <= `RST_BYTE;
            cmp_act_b_ff <= `RST_BYTE;
        end
        else
        begin
            if (wr_cmp_a)
                cmp_buf_a_ff <= pwdata[7:0];
            if (wr_cmp_b)
                cmp_buf_b_ff <= pwdata[7:0];
            // Double buffer transfer at the mode's update point
            if (load_buf)
            begin
                cmp_act_a_ff <= cmp_buf_a_ff;
                cmp_act_b_ff <= cmp_buf_b_ff;
            end
        end
    end

    // Prescaler and pin synchroniser
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_ff <= 10'h000;
            pin_sync_ff <= 3'b000;
        end
        else
        begin
            // Prescaler runs only while an internal divider is chosen
            if ((clk_sel >= 3'd2) && (clk_sel <= 3'd5))
                presc_ff <= presc_ff + 10'h001;
            else
                presc_ff <= 10'h000;
            // Two-stage sync, third stage for edge detection
            pin_sync_ff <= {pin_sync_ff[1:0], ext_count_pin};
        end
    end

    // Counter and direction
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_ff <= `RST_BYTE;
            up_ff <= 1'b1;
        end
        else if (wr_count)
        begin
            // Software write overrides the tick
            count_ff <= pwdata[7:0];
        end
        else if (!is_phase)
        begin
            // Single slope: wrap from TOP to BOTTOM
            up_ff <= 1'b1;
            if (run)
                count_ff <= at_top ? `BOTTOM : count_ff + 8'h01;
        end
        else if (run)
        begin
            // Dual slope: turn at TOP and at BOTTOM
            if (up_ff && at_top)
            begin
                up_ff <= 1'b0;
                count_ff <= at_bottom ? `BOTTOM : count_ff - 8'h01;
            end
            else if (up_ff)
                count_ff <= count_ff + 8'h01;
            else if (at_bottom)
            begin
                up_ff <= 1'b1;
                count_ff <= at_top ? `BOTTOM : count_ff + 8'h01;
            end
            else
                count_ff <= count_ff - 8'h01;
        end
    end

    // Flags and interrupt line
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_ff <= 3'b000;
            irq <= 1'b0;
        end
        else
        begin
            flag_ff <= nxt_flag;
            irq <= |(nxt_flag & mask_ff);
        end
    end

    // Compare output units, one per channel
    wire [1:0] act_w [0:1];
    wire [7:0] cmp_w [0:1];
    assign act_w[0] = ctrl_a_ff[`CA_ACT_A_HI:`CA_ACT_A_LO];
    assign act_w[1] = ctrl_a_ff[`CA_ACT_B_HI:`CA_ACT_B_LO];
    assign cmp_w[0] = cmp_act_a_ff;
    assign cmp_w[1] = cmp_act_b_ff;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_out
            // Channel-level decode
            wire [1:0] act = act_w[ch];
            wire cmp_top = (cmp_w[ch] == top_val) && act[1];
            wire toggle_ok = (!is_phase && !is_fast) || ((ch == 0) && (mode == 3'd7));
            reg nxt_wave;

            // Next waveform level
            always @*
            begin
                nxt_wave = wave_ff[ch];
                if (is_phase)
                begin
                    if (cmp_top)
                    begin
                        // Match ignored, action done at TOP
                        if (top_ev)
                            nxt_wave = (act == 2'b10);
                    end
                    else if (match[ch] && (act == 2'b10))
                        nxt_wave = !up_ff;
                    else if (match[ch] && (act == 2'b11))
                        nxt_wave = up_ff;
                end
                else if (is_fast)
                begin
                    // Match edge, then wrap edge wins
                    if (match[ch] && act[1])
                        nxt_wave = act[0];
                    else if (match[ch] && (act == 2'b01) && toggle_ok)
                        nxt_wave = !wave_ff[ch];
                    if (run && at_top && act[1])
                        nxt_wave = !act[0];
                end
                else if (match[ch])
                begin
                    // Normal and clear-on-match actions
                    case (act)
                        2'b01: nxt_wave = !wave_ff[ch];
                        2'b10: nxt_wave = 1'b0;
                        2'b11: nxt_wave = 1'b1;
                        default: nxt_wave = wave_ff[ch];
                    endcase
                end
            end

            // Output state and pin enable
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    wave_ff[ch] <= 1'b0;
                    wave_en_ff[ch] <= 1'b0;
                end
                else
                begin
                    wave_ff[ch] <= nxt_wave;
                    // 00 and reserved 01 leave the pin to the port
                    wave_en_ff[ch] <= act[1] || ((act == 2'b01) && toggle_ok);
                end
            end
        end
    endgenerate

    // Pin-side outputs straight from flops
    assign wave_out_a = wave_ff[0];
    assign wave_out_b = wave_ff[1];
    assign wave_en_a = wave_en_ff[0];
    assign wave_en_b = wave_en_ff[1];

endmodule // timer8_waveform_generator

// ---- timer8_regs.vh ----
// Register map, field positions, reset values and prescaler taps of the 8-bit timer.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Operation
// - Count and both compare registers are 8-bit
// - Overflow, match A, match B flags together
// - Each flag has its own mask bit
// - Prescaled clock or external pin, edge selectable
// - Phase mode B: 00 disconnected, 01 reserved
// - Phase B 10: clear up, set down
// - Phase B 11: set up, clear down
// - B at TOP: act at TOP instead
// - Control A bits 3:2 read zero
// - Three mode bits select sequence and TOP
// - Mode 0: TOP FF, immediate, overflow MAX
// - Mode 1: TOP FF, load TOP, overflow BOTTOM
// - Mode 2: TOP compare A, immediate, MAX
// - Mode 3: TOP FF, load BOTTOM, MAX
// - Mode 5: TOP compare A, load TOP, BOTTOM
// - Mode 7: TOP compare A, load BOTTOM, TOP
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH
// Byte offsets
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_COUNT 8'h08
`define OFS_CMP_A 8'h0C
`define OFS_CMP_B 8'h10
`define OFS_MASK 8'h14
`define OFS_FLAG 8'h18
// Control A fields
`define CA_ACT_A_HI 7
`define CA_ACT_A_LO 6
`define CA_ACT_B_HI 5
`define CA_ACT_B_LO 4
// Control B fields
`define CB_MODE_HI 3
// Flag / mask bit positions
`define FLG_OVF 0
`define FLG_MA 1
`define FLG_MB 2
// Fixed values
`define TOP_FIXED 8'hFF
`define BOTTOM 8'h00
`define RST_BYTE 8'h00
// Prescaler masks: tick when masked bits are all ones
`define DIV8_MASK 10'h007
`define DIV64_MASK 10'h03F
`define DIV256_MASK 10'h0FF
`define DIV1024_MASK 10'h3FF
`endif

// ---- timer8_waveform_generator_assertions.sv ----
// Checker for the timer's APB handshake, read data and channel B pin enable.
// Assumes it is bound to the timer top and sees only its ports.
`timescale 1ns/10ps
module timer8_waveform_generator_assertions
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pin enable and interrupt
    input wire wave_en_b,
    input wire irq
);
    reg [1:0] act_b_ff; // Shadow of channel B action
    reg [2:0] mask_ff; // Shadow of interrupt mask
    wire wr_done = psel && penable && pready && pwrite; // Write completes
    wire rd_done = psel && penable && pready && !pwrite; // Read completes
    // Follow control A and mask writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_b_ff <= 2'b00;
            mask_ff <= 3'b000;
        end
        else if (wr_done && paddr == 8'h00)
            act_b_ff <= pwdata[5:4];
        else if (wr_done && paddr == 8'h14)
            mask_ff <= pwdata[2:0];
    end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_one_wait; psel && penable && !pready |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr alone");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("prdata not zero");
    property p_unmapped; rd_done && paddr > 8'h18 |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_ctrl_rsv; rd_done && paddr == 8'h00 |-> prdata[3:2] == 2'b00; endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bits");
    property p_width; rd_done && paddr inside {8'h08, 8'h0C, 8'h10} |-> prdata[31:8] == 24'h0; endproperty
    a_width: assert property (p_width) else $error("wide value");
    property p_flags; rd_done && paddr == 8'h18 |-> prdata[31:3] == 29'h0; endproperty
    a_flags: assert property (p_flags) else $error("extra flags");
    property p_b_off; (act_b_ff == 2'b00) [*2] |-> !wave_en_b; endproperty
    a_b_off: assert property (p_b_off) else $error("B driven");
    property p_b_on; act_b_ff[1] [*2] |-> wave_en_b; endproperty
    a_b_on: assert property (p_b_on) else $error("B not driven");
    property p_mask; (mask_ff == 3'b000) [*2] |-> !irq; endproperty
    a_mask: assert property (p_mask) else $error("irq masked");
    // Main scenarios
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_b_on: cover property (wave_en_b);
endmodule // timer8_waveform_generator_assertions

// ---- timer8_pin_source.sv ----
// Model of the external count source feeding the timer's count pin.
// Assumes the bench calls pulses() from its own process.
`timescale 1ns/10ps
module timer8_pin_source
(
    // Bus clock
    input wire pclk,
    // Count pin to the timer
    output reg ext_count_pin
);
    initial ext_count_pin = 1'b0; // Idle low between bursts
    // Emit n pulses, high for len clocks, low for len clocks plus one between pulses
    task pulses(input integer n, input integer len);
        integer j;
    begin
        for (j = 0; j < n; j = j + 1)
        begin
            @(posedge pclk);
            ext_count_pin <= 1'b1;
            repeat (len) @(posedge pclk);
            ext_count_pin <= 1'b0;
            repeat (len) @(posedge pclk);
        end
    end
    endtask
endmodule // timer8_pin_source

// ---- tb_timer8_waveform_generator.sv ----
// Directed bench for the 8-bit timer over APB and its count pin.
// Assumes the timer, its checker and the pin source model.
`timescale 1ns/10ps
module tb_timer8_waveform_generator;
    reg pclk; // Bus clock
    reg presetn; // Active-low reset
    reg psel; // APB select
    reg penable; // APB enable
    reg pwrite; // APB direction
    reg [7:0] paddr; // APB address
    reg [31:0] pwdata; // APB write data
    wire [31:0] prdata; // APB read data
    wire pready; // APB ready
    wire pslverr; // APB error
    wire ext_count_pin; // Count pin
    wire wave_out_a; // Channel A wave
    wire wave_out_b; // Channel B wave
    wire wave_en_a; // Channel A drive
    wire wave_en_b; // Channel B drive
    wire irq; // Interrupt
    integer n_fail; // Mismatches
    integer check_count; // Comparisons
    integer i; // Loop index
    integer k; // Wait bound
    reg [31:0] rd; // Last read data
    reg err; // Last error bit
    reg [14:0] md; // Mode per run
    reg [4:0] ovf; // Overflow per run
    timer8_waveform_generator uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b), .irq(irq));
    timer8_pin_source u_src (.pclk(pclk), .ext_count_pin(ext_count_pin));
    // Clock, 50 ns
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Verdict and end of run
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    // Compare and count
    task chk(input [31:0] g, input [31:0] e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    // One APB transfer, bounded wait for pready
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            k = k + 1;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t no pready", $time);
            print_verdict;
        end
        @(posedge pclk);
    end
    endtask
    // Write, and read with compare
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rc(input [7:0] a, input [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    end
    endtask
    // Reset held 10 clocks
    task do_reset;
    begin
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    end
    endtask
    // Fresh start on pin counting, TOP 4 from A
    task pin_setup(input [7:0] ca, input [7:0] cb, input [7:0] b);
    begin
        do_reset;
        wr(8'h0C, 32'h4);
        wr(8'h10, {24'h0, b});
        wr(8'h00, {24'h0, ca});
        wr(8'h04, {24'h0, cb});
    end
    endtask
    // Pin pulses then settle past the synchroniser
    task pls(input integer n, input integer len);
    begin
        u_src.pulses(n, len);
        repeat (4) @(posedge pclk);
    end
    endtask
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        n_fail = 0;
        check_count = 0;
        do_reset;
        for (i = 0; i < 8; i = i + 1)
            rc(i * 4, 32'h0);
        wr(8'h08, 32'h1234_56AB);
        rc(8'h08, 32'hAB);
        wr(8'h0C, 32'hFFFF_FF5A);
        rc(8'h0C, 32'h5A);
        wr(8'h00, 32'hFF);
        rc(8'h00, 32'hF3);
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h18, 32'h7);
        rc(8'h18, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFF);
        chk({31'h0, err}, 32'h1);
        rc(8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test registers done");
        wr(8'h08, 32'hFD);
        wr(8'h04, 32'h1);
        repeat (20) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h04, 32'h0);
        rc(8'h18, 32'h7);
        wr(8'h08, 32'hFD);
        wr(8'h14, 32'h1);
        wr(8'h04, 32'h1);
        for (k = 0; irq !== 1'b1 && k < 50; k = k + 1)
            @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h04, 32'h0);
        rc(8'h18, 32'h7);
        rc(8'h18, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupts done");
        md = {3'd5, 3'd7, 3'd2, 3'd3, 3'd1};
        ovf = 5'b11010;
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(8'h04, 32'h0);
            wr(8'h00, 32'h0);
            wr(8'h0C, 32'h10);
            wr(8'h08, 32'h0);
            apb(1'b0, 8'h18, 32'h0);
            wr(8'h00, {30'h0, md[3 * i +: 2]});
            wr(8'h04, {28'h0, md[3 * i + 2], 3'h1});
            repeat (300) @(posedge pclk);
            wr(8'h04, 32'h0);
            apb(1'b0, 8'h18, 32'h0);
            chk({31'h0, rd[0]}, {31'h0, ovf[i]});
            apb(1'b0, 8'h08, 32'h0);
            if (i >= 2)
                chk({31'h0, rd[7:0] <= 8'h10}, 32'h1);
        end
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h2);
        repeat (80) @(posedge pclk);
        wr(8'h04, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, rd[7:0] > 8'h08 && rd[7:0] < 8'h0D}, 32'h1);
        // Slower dividers: 2104 cycles give 32, 8 and 2 ticks
        for (i = 3; i < 6; i = i + 1)
        begin
            wr(8'h08, 32'h0);
            wr(8'h04, i);
            repeat (2100) @(posedge pclk);
            wr(8'h04, 32'h0);
            rc(8'h08, 32'h20 >> (2 * (i - 3)));
        end
        $display("test modes done");
        for (i = 0; i < 4; i = i + 1)
        begin
            pin_setup({2'b00, i[1:0], 4'h1}, 8'h0F, 8'h02);
            pls(3, 3);
            chk({31'h0, wave_en_b}, {31'h0, i[1]});
            if (i[1])
                chk({31'h0, wave_out_b}, {31'h0, i[0]});
            pls(4, 6);
            if (i[1])
                chk({31'h0, wave_out_b}, {31'h0, !i[0]});
            rc(8'h08, 32'h1);
        end
        pin_setup(8'h21, 8'h0F, 8'h04);
        pls(4, 3);
        chk({31'h0, wave_out_b}, 32'h0);
        pls(1, 3);
        chk({31'h0, wave_out_b}, 32'h1);
        pin_setup(8'h43, 8'h0E, 8'h00);
        pls(6, 3);
        rc(8'h08, 32'h1);
        chk({30'h0, wave_en_a, wave_out_a}, 32'h3);
        $display("test pin waves done");
        print_verdict;
    end
endmodule // tb_timer8_waveform_generator
bind timer8_waveform_generator timer8_waveform_generator_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wave_en_b(wave_en_b), .irq(irq));
